// [shared/hlgc_cfg.svh]
// Purpose: Constants for the hex low-side gate control and diagnostic block.
// Assumes: Core clock of 200 MHz; times are in nanoseconds.
// Notes:   Cycle counts round least times up to whole cycles.
`ifndef HLGC_CFG_SVH
`define HLGC_CFG_SVH
`define HLGC_NCH          6
`define HLGC_CLK_MHZ      200
`define HLGC_CYC(ns)      (((ns) * `HLGC_CLK_MHZ + 999) / 1000)
`define HLGC_TBL_ON0_NS   6000
`define HLGC_TBL_ON1_NS   12000
`define HLGC_TBL_ON2_NS   26000
`define HLGC_TBL_ON3_NS   52000
`define HLGC_TBL_ON4_NS   16900
`define HLGC_TBL_ON5_NS   32500
`define HLGC_TBL_ON6_NS   77900
`define HLGC_TBL_ON7_NS   127300
`define HLGC_TBL_OFF0_NS  55000
`define HLGC_TBL_OFF1_NS  80000
`define HLGC_TBL_OFF2_NS  160000
`define HLGC_TBL_OFF3_NS  320000
`define HLGC_FILT_NS      10000
`define HLGC_RETRY_NS     1000000
`define HLGC_FRAME_BITS   5'h10
`define HLGC_A_GATE       3'h0
`define HLGC_A_PULSE      3'h1
`define HLGC_A_CFG1       3'h2
`define HLGC_A_OLEN       3'h3
`define HLGC_A_STLO       3'h4
`define HLGC_A_STHI       3'h5
`define HLGC_A_REV        3'h6
`define HLGC_A_TEST       3'h7
`define HLGC_ON_SEL_DEF   3'h2
`define HLGC_OFF_SEL_DEF  2'h2
`define HLGC_OL_EN_DEF    6'h3f
`define HLGC_SEL_ALL      3'h7
`define HLGC_PAR_ERR_WORD 16'heaaa
`define HLGC_FRM_ERR_WORD 16'heaa9
`endif

// [shared/hlgc_pkg.sv]
// Purpose: Types shared by the gate control core and its serial link.
// Assumes: hlgc_cfg.svh supplies the constants.
// Notes:   Status codes are ordered so that a lower code has higher priority.
package hlgc_pkg;
`include "hlgc_cfg.svh"
    typedef logic [17:0] hlgc_cnt_t;

    typedef enum logic [2:0] {
        ST_LATCHED_OFF = 3'h0,
        ST_SUPPLY      = 3'h1,
        ST_GROUND      = 3'h2,
        ST_OPEN        = 3'h3,
        ST_DONE        = 3'h4,
        ST_ON_OK       = 3'h5,
        ST_OFF_OK      = 3'h6,
        ST_NOT_DONE    = 3'h7
    } hlgc_st_t;

    typedef struct packed {
        logic       out;
        logic       shrt;
        logic       pulse;
        logic       poff;
        logic [2:0] on_sel;
        logic [1:0] off_sel;
        hlgc_cnt_t  blank;
        hlgc_cnt_t  filt;
        hlgc_cnt_t  retry;
        hlgc_st_t   st;
    } hlgc_chan_t;

    typedef struct packed {
        hlgc_chan_t [`HLGC_NCH-1:0] ch;
        logic [`HLGC_NCH-1:0]       gate;
        logic [`HLGC_NCH-1:0]       mode;
        logic [`HLGC_NCH-1:0]       ol_en;
        logic [15:0]                resp;
        logic                       err_par;
        logic                       err_frm;
        logic                       en_prev;
        logic                       gd_prev;
        logic                       cs_prev;
        logic                       flag_oe;
    } hlgc_core_t;

    typedef struct packed {
        logic [15:0] rx;
        logic [15:0] tx;
        logic [4:0]  cnt;
    } hlgc_link_t;

    function automatic hlgc_chan_t hlgc_chan_def();
        hlgc_chan_t c;
        c         = '0;
        c.on_sel  = `HLGC_ON_SEL_DEF;
        c.off_sel = `HLGC_OFF_SEL_DEF;
        c.st      = ST_NOT_DONE;
        return c;
    endfunction : hlgc_chan_def
endpackage : hlgc_pkg

// [rtl/hlgc_sync.sv]
// Purpose: Two-flop synchroniser for a bundle of asynchronous pins.
// Assumes: Each bit is independent; no bus coherence is needed.
// Notes:   The first stage is read only by the second stage.
module hlgc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         resetn,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= '0;
            q_reg    <= '0;
        end else begin
            meta_reg <= d;
            q_reg    <= meta_reg;
        end
    end

    assign q = q_reg;
endmodule : hlgc_sync

// [rtl/hlgc_link.sv]
// Purpose: Serial frame shifter running on the link clock.
// Assumes: Mode 0 framing, MSB first, 16 bits per frame while select is low.
// Notes:   Frame contents are held stable while select is high for the core.
module hlgc_link
    import hlgc_pkg::*;
(
    // Link clock and reset
    input  wire logic        spi_sclk,
    input  wire logic        resetn,
    // Link pins
    input  wire logic        chip_select_n,
    input  wire logic        spi_mosi,
    output logic             spi_miso_o,
    output logic             spi_miso_oe,
    // Core side, quasi-static
    input  wire logic [15:0] resp_word,
    input  wire logic        spi_en,
    output logic      [15:0] rx_word,
    output logic      [4:0]  bit_cnt
);
    hlgc_link_t link_reg;
    hlgc_link_t link_next;
    logic       armed_reg;

    // Select high arms the next frame; the first clock edge restarts it.
    always_ff @(posedge spi_sclk or posedge chip_select_n) begin
        if (chip_select_n) begin
            armed_reg <= 1'b1;
        end else begin
            armed_reg <= 1'b0;
        end
    end

    always_comb begin
        link_next = link_reg;
        if (armed_reg) begin
            link_next.rx  = {15'h0, spi_mosi};
            link_next.tx  = {resp_word[14:0], 1'b0};
            link_next.cnt = 5'h1;
        end else begin
            link_next.rx = {link_reg.rx[14:0], spi_mosi};
            link_next.tx = {link_reg.tx[14:0], 1'b0};
            if (link_reg.cnt != 5'h1f) begin
                link_next.cnt = link_reg.cnt + 5'h1;
            end
        end
    end

    always_ff @(posedge spi_sclk or negedge resetn) begin
        if (!resetn) begin
            link_reg <= '0;
        end else begin
            link_reg <= link_next;
        end
    end

    assign spi_miso_o  = armed_reg ? resp_word[15] : link_reg.tx[15];
    assign spi_miso_oe = ~chip_select_n & spi_en;
    assign rx_word     = link_reg.rx;
    assign bit_cnt     = link_reg.cnt;
endmodule : hlgc_link

// [rtl/hlgc_top.sv]
// Purpose: Six-channel gate control, timers and fault status with frame decode.
// Assumes: Comparator results arrive as asynchronous pins; resetn is power-on.
// Notes:   Frame fields are addr[15:13], data[12:1], odd parity in bit 0.
// How it works
// - Test register ignores written data and echoes received data.
// - After a frame error, next test register frame returns fixed error pattern.
// - Output on only when enabled, not shorted, and input or gate bit set, or when a pulse inverts it.
// - Master reset low forces outputs low, defaults registers, blocks serial and flag.
// - Disable high forces outputs low, stops diagnostics and retry, keeps registers.
// - Disable returning low releases latched channels and reopens status updates.
// - Output change starts on or off blanking, feedback sampled at its end.
// - Threshold crossing starts a filter timer, sampled at expiry, may extend blanking.
// - Each channel has own timers; blanking times selectable per channel.
// - New blanking selection applies only at the next timer start.
// - All blanking timers restart at power-on and whenever operation becomes enabled.
// - Shorted load checked while on, ground and open load while off.
// - On-state fault protects channel and flags; off-state fault only flags.
// - Status is a three bit priority code read through two registers.
// - Stored status only moves to higher priority results.
// - Status read returns status to not complete unless latched off or a latch-mode supply short; master reset always does.
// - Diagnostics idle unless enabled; open-load check follows per channel enable.
// - Pulse requests start on the select rising edge, regardless of outputs.
// - Pulse suppressed when disabled, conflicting, supply short stored, busy or retrying.
// - Off pulse forces open-load check, inverts output for off blanking.
// - On pulse inverts output for on blanking and latches the result.
// - Status codes zero to seven, from latched off to not complete.
// - Reading a supply short in latch mode leaves latched-off status.
// - Open-load checking is enabled on all channels after reset.
module hlgc_top
    import hlgc_pkg::*;
#(
    parameter hlgc_cnt_t   ON_CYC [8]  = '{
        hlgc_cnt_t'(`HLGC_CYC(`HLGC_TBL_ON0_NS)), hlgc_cnt_t'(`HLGC_CYC(`HLGC_TBL_ON1_NS)),
        hlgc_cnt_t'(`HLGC_CYC(`HLGC_TBL_ON2_NS)), hlgc_cnt_t'(`HLGC_CYC(`HLGC_TBL_ON3_NS)),
        hlgc_cnt_t'(`HLGC_CYC(`HLGC_TBL_ON4_NS)), hlgc_cnt_t'(`HLGC_CYC(`HLGC_TBL_ON5_NS)),
        hlgc_cnt_t'(`HLGC_CYC(`HLGC_TBL_ON6_NS)), hlgc_cnt_t'(`HLGC_CYC(`HLGC_TBL_ON7_NS))},
    parameter hlgc_cnt_t   OFF_CYC [4] = '{
        hlgc_cnt_t'(`HLGC_CYC(`HLGC_TBL_OFF0_NS)), hlgc_cnt_t'(`HLGC_CYC(`HLGC_TBL_OFF1_NS)),
        hlgc_cnt_t'(`HLGC_CYC(`HLGC_TBL_OFF2_NS)), hlgc_cnt_t'(`HLGC_CYC(`HLGC_TBL_OFF3_NS))},
    parameter hlgc_cnt_t   FILT_CYC    = hlgc_cnt_t'(`HLGC_CYC(`HLGC_FILT_NS)),
    parameter hlgc_cnt_t   RETRY_CYC   = hlgc_cnt_t'(`HLGC_CYC(`HLGC_RETRY_NS)),
    // Revision word value is arbitrary.
    parameter logic [11:0] REV_DATA    = 12'h0a5
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 resetn,
    // Serial link
    input  wire logic                 spi_sclk,
    input  wire logic                 chip_select_n,
    input  wire logic                 spi_mosi,
    output logic                      spi_miso_o,
    output logic                      spi_miso_oe,
    // Control pins
    input  wire logic                 master_reset_n,
    input  wire logic                 global_disable,
    input  wire logic [`HLGC_NCH-1:0] par_in,
    // Drain feedback comparators
    input  wire logic [`HLGC_NCH-1:0] drain_feedback_over,
    input  wire logic [`HLGC_NCH-1:0] drain_feedback_low,
    input  wire logic [`HLGC_NCH-1:0] drain_feedback_mid,
    // Gate drive and fault flag
    output logic      [`HLGC_NCH-1:0] drive_output,
    output logic                      fault_flag_n_o,
    output logic                      fault_flag_n_oe
);
    localparam int SW = 4 * `HLGC_NCH + 3;

    hlgc_core_t           core_reg;
    hlgc_core_t           core_next;
    hlgc_chan_t           ch_v;
    logic [SW-1:0]        sync_q;
    logic [`HLGC_NCH-1:0] par_s;
    logic [`HLGC_NCH-1:0] over_s;
    logic [`HLGC_NCH-1:0] low_s;
    logic [`HLGC_NCH-1:0] mid_s;
    logic                 mr_s;
    logic                 gd_s;
    logic                 cs_s;
    logic [15:0]          rx_word;
    logic [4:0]           bit_cnt;
    logic                 en;
    logic                 restart;
    logic                 cs_rise;
    logic                 ev_any;
    logic                 rd_lo;
    logic                 rd_hi;
    logic [`HLGC_NCH-1:0] pul_on;
    logic [`HLGC_NCH-1:0] pul_off;
    logic [2:0]           addr;
    logic [11:0]          data;
    logic [11:0]          rdata;
    logic [11:0]          st_lo;
    logic [11:0]          st_hi;
    logic                 base;
    logic                 want;
    logic                 olok;
    logic                 thr;
    logic                 samp;
    hlgc_st_t             res;

    hlgc_sync #(
        .W (SW)
    ) u_sync (
        .clk    (clk),
        .resetn (resetn),
        .d      ({par_in, drain_feedback_over, drain_feedback_low, drain_feedback_mid,
                  master_reset_n, global_disable, chip_select_n}),
        .q      (sync_q)
    );

    assign {par_s, over_s, low_s, mid_s, mr_s, gd_s, cs_s} = sync_q;

    // Frame words are read only after select has settled high.
    hlgc_link u_link (
        .spi_sclk      (spi_sclk),
        .resetn        (resetn),
        .chip_select_n (chip_select_n),
        .spi_mosi      (spi_mosi),
        .spi_miso_o    (spi_miso_o),
        .spi_miso_oe   (spi_miso_oe),
        .resp_word     (core_reg.resp),
        .spi_en        (mr_s),
        .rx_word       (rx_word),
        .bit_cnt       (bit_cnt)
    );

    function automatic hlgc_core_t core_def();
        hlgc_core_t d;
        d = '0;
        for (int i = 0; i < `HLGC_NCH; i++) begin
            d.ch[i] = hlgc_chan_def();
        end
        d.ol_en = `HLGC_OL_EN_DEF;
        // Select idles high, so no false frame end follows either reset.
        d.cs_prev = 1'b1;
        d.resp  = {`HLGC_A_REV, REV_DATA, ~^{`HLGC_A_REV, REV_DATA}};
        return d;
    endfunction : core_def

    // Status bits are grouped by code bit across three channels.
    always_comb begin
        st_lo = '0;
        st_hi = '0;
        for (int k = 0; k < 3; k++) begin
            st_lo[6+k] = core_reg.ch[k].st[2];
            st_lo[3+k] = core_reg.ch[k].st[1];
            st_lo[k]   = core_reg.ch[k].st[0];
            st_hi[6+k] = core_reg.ch[k+3].st[2];
            st_hi[3+k] = core_reg.ch[k+3].st[1];
            st_hi[k]   = core_reg.ch[k+3].st[0];
        end
        st_lo[9] = gd_s;
        st_hi[9] = gd_s;
    end

    always_comb begin
        core_next = core_reg;
        en        = mr_s & ~gd_s;
        restart   = en & ~core_reg.en_prev;
        cs_rise   = cs_s & ~core_reg.cs_prev;
        ev_any    = 1'b0;
        rd_lo     = 1'b0;
        rd_hi     = 1'b0;
        pul_on    = '0;
        pul_off   = '0;
        addr      = rx_word[15:13];
        data      = rx_word[12:1];
        rdata     = data;
        ch_v      = '0;
        base      = 1'b0;
        want      = 1'b0;
        olok      = 1'b0;
        thr       = 1'b0;
        samp      = 1'b0;
        res       = ST_NOT_DONE;
        core_next.en_prev = en;
        core_next.gd_prev = gd_s;
        core_next.cs_prev = cs_s;

        if (!mr_s) begin
            core_next = core_def();
            core_next.gd_prev = gd_s;
        end else if (cs_rise) begin
            if (bit_cnt != `HLGC_FRAME_BITS) begin
                core_next.err_frm = 1'b1;
                core_next.err_par = 1'b0;
            end else if (!(^rx_word)) begin
                core_next.err_par = 1'b1;
                core_next.err_frm = 1'b0;
            end else begin
                unique case (addr)
                    `HLGC_A_GATE: begin
                        core_next.gate = data[5:0];
                        core_next.mode = data[11:6];
                    end
                    `HLGC_A_PULSE: begin
                        pul_on  = data[5:0];
                        pul_off = data[11:6];
                    end
                    `HLGC_A_CFG1: begin
                        for (int i = 0; i < `HLGC_NCH; i++) begin
                            if (data[2:0] == `HLGC_SEL_ALL || data[2:0] == 3'(i)) begin
                                core_next.ch[i].on_sel  = {data[4], data[6:5]};
                                core_next.ch[i].off_sel = data[8:7];
                            end
                        end
                    end
                    `HLGC_A_OLEN: begin
                        core_next.ol_en = data[5:0];
                    end
                    `HLGC_A_STLO: begin
                        rdata = st_lo;
                        rd_lo = 1'b1;
                    end
                    `HLGC_A_STHI: begin
                        rdata = st_hi;
                        rd_hi = 1'b1;
                    end
                    `HLGC_A_REV: begin
                        rdata = REV_DATA;
                    end
                    `HLGC_A_TEST: begin
                        rdata = data;
                    end
                endcase
                core_next.resp = {addr, rdata, ~^{addr, rdata}};
                if (addr == `HLGC_A_TEST && core_next.err_par) begin
                    core_next.resp    = `HLGC_PAR_ERR_WORD;
                    core_next.err_par = 1'b0;
                end else if (addr == `HLGC_A_TEST && core_next.err_frm) begin
                    core_next.resp    = `HLGC_FRM_ERR_WORD;
                    core_next.err_frm = 1'b0;
                end
            end
        end

        for (int i = 0; i < `HLGC_NCH; i++) begin
            ch_v = core_next.ch[i];
            if (mr_s) begin
                if (gd_s) begin
                    ch_v.retry = '0;
                    ch_v.pulse = 1'b0;
                    ch_v.blank = '0;
                    ch_v.filt  = '0;
                end
                if (!gd_s && core_reg.gd_prev) begin
                    ch_v.shrt = 1'b0;
                    if (ch_v.st == ST_LATCHED_OFF) begin
                        ch_v.st = ST_NOT_DONE;
                    end
                end
                if ((rd_lo && i < 3) || (rd_hi && i >= 3)) begin
                    if (ch_v.st == ST_SUPPLY && !core_reg.mode[i]) begin
                        ch_v.st = ST_LATCHED_OFF;
                    end else if (ch_v.st != ST_LATCHED_OFF) begin
                        ch_v.st = ST_NOT_DONE;
                    end
                end
                if (!core_reg.mode[i]) begin
                    ch_v.retry = '0;
                end
                if ((pul_on[i] ^ pul_off[i]) && en && ch_v.st != ST_SUPPLY &&
                    !ch_v.pulse && ch_v.blank == '0 && ch_v.retry == '0) begin
                    ch_v.pulse = 1'b1;
                    ch_v.poff  = pul_off[i];
                    if (ch_v.st == ST_LATCHED_OFF) begin
                        ch_v.st   = ST_NOT_DONE;
                        ch_v.shrt = 1'b0;
                    end
                end
                base = en & ~ch_v.shrt & (ch_v.retry == '0) &
                       (par_s[i] | core_reg.gate[i]);
                want = en & (ch_v.pulse ? ~base : base);
                olok = core_reg.ol_en[i] | (ch_v.pulse & ch_v.poff);
                if (want != ch_v.out || restart) begin
                    ch_v.out   = want;
                    ch_v.blank = want ? ON_CYC[ch_v.on_sel] : OFF_CYC[ch_v.off_sel];
                    ch_v.filt  = '0;
                end else if (en) begin
                    thr  = ch_v.out ? over_s[i] : (low_s[i] | (mid_s[i] & olok));
                    samp = (ch_v.blank == 18'h1 && ch_v.filt == '0) ||
                           (ch_v.filt == 18'h1 && ch_v.blank <= 18'h1);
                    if (ch_v.blank != '0) begin
                        ch_v.blank = ch_v.blank - 18'h1;
                    end
                    if (!thr) begin
                        ch_v.filt = '0;
                    end else if (ch_v.filt == '0) begin
                        ch_v.filt = FILT_CYC;
                    end else begin
                        ch_v.filt = ch_v.filt - 18'h1;
                    end
                end
                if (ch_v.retry != '0) begin
                    ch_v.retry = ch_v.retry - 18'h1;
                end
                if (samp) begin
                    if (ch_v.out) begin
                        res = over_s[i] ? ST_SUPPLY : ST_ON_OK;
                    end else if (low_s[i]) begin
                        res = ST_GROUND;
                    end else if (mid_s[i] && olok) begin
                        res = ST_OPEN;
                    end else begin
                        res = ST_OFF_OK;
                    end
                    if (res <= ST_OPEN) begin
                        ev_any = 1'b1;
                    end
                    if (res == ST_SUPPLY) begin
                        if (core_reg.mode[i]) begin
                            ch_v.retry = RETRY_CYC;
                        end else begin
                            ch_v.shrt = 1'b1;
                        end
                    end
                    if (res < ch_v.st) begin
                        ch_v.st = res;
                    end else if ((ch_v.st == ST_ON_OK && res == ST_OFF_OK) ||
                                 (ch_v.st == ST_OFF_OK && res == ST_ON_OK)) begin
                        ch_v.st = ST_DONE;
                    end
                    ch_v.pulse = 1'b0;
                end
            end
            core_next.ch[i] = ch_v;
        end

        if (!mr_s || gd_s || !cs_s) begin
            core_next.flag_oe = 1'b0;
        end else if (ev_any) begin
            core_next.flag_oe = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            core_reg <= core_def();
        end else begin
            core_reg <= core_next;
        end
    end

    always_comb begin
        for (int i = 0; i < `HLGC_NCH; i++) begin
            drive_output[i] = core_reg.ch[i].out;
        end
    end

    assign fault_flag_n_o  = 1'b0;
    assign fault_flag_n_oe = core_reg.flag_oe;
endmodule : hlgc_top

// [bench/hlgc_chk_sva.sv]
// Purpose: Port-level checks of the gate control block.
// Assumes: Control pins reach the outputs within five clock cycles.
// Notes:   Bound to hlgc_top from the testbench top file.
`include "hlgc_cfg.svh"
module hlgc_chk
    import hlgc_pkg::*;
(
    // Clock and reset
    input wire logic                 clk,
    input wire logic                 resetn,
    // Pins
    input wire logic                 chip_select_n,
    input wire logic                 spi_miso_oe,
    input wire logic                 master_reset_n,
    input wire logic                 global_disable,
    input wire logic [`HLGC_NCH-1:0] drive_output,
    input wire logic                 fault_flag_n_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_mrst; !master_reset_n [*6]; endsequence
    sequence s_dis; global_disable [*6]; endsequence
    property p_mrst_drive; s_mrst |-> drive_output == '0; endproperty
    a_mrst_drive: assert property (p_mrst_drive) else $error("drive in master reset");
    property p_mrst_miso; s_mrst |-> !spi_miso_oe; endproperty
    a_mrst_miso: assert property (p_mrst_miso) else $error("serial out in reset");
    property p_mrst_flag; s_mrst |-> !fault_flag_n_oe; endproperty
    a_mrst_flag: assert property (p_mrst_flag) else $error("flag in master reset");
    property p_dis_drive; s_dis |-> drive_output == '0; endproperty
    a_dis_drive: assert property (p_dis_drive) else $error("drive while disabled");
    property p_dis_flag; s_dis |-> !fault_flag_n_oe; endproperty
    a_dis_flag: assert property (p_dis_flag) else $error("flag while disabled");
    property p_cs_flag; !chip_select_n [*6] |-> !fault_flag_n_oe; endproperty
    a_cs_flag: assert property (p_cs_flag) else $error("flag while selected");
    property p_rise; $rose(|drive_output) |-> master_reset_n && !global_disable; endproperty
    a_rise: assert property (p_rise) else $error("drive rose while blocked");
    property p_miso_sel; spi_miso_oe |-> !chip_select_n && master_reset_n; endproperty
    a_miso_sel: assert property (p_miso_sel) else $error("serial out unselected");
endmodule : hlgc_chk

// [bench/hlgc_host.sv]
// Purpose: Serial host that frames words on its own link clock.
// Assumes: Link clock idles low and runs only inside a frame.
// Notes:   A short bit count makes a framing fault on purpose.
module hlgc_host (
    // Link pins
    output logic       spi_sclk,
    output logic       chip_select_n,
    output logic       spi_mosi,
    input  wire logic  spi_miso_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        spi_sclk = 1'b0;
        chip_select_n = 1'b1;
        spi_mosi = 1'b0;
    end
    task automatic frame(input logic [15:0] w, input int n, output logic [15:0] r);
        r = '0;
        chip_select_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            spi_mosi = w[15-i];
            #15;
            r[15-i] = spi_miso_o;
            spi_sclk = 1'b1;
            #15;
            spi_sclk = 1'b0;
        end
        // Released data line must not look like a held bit.
        spi_mosi = ~spi_mosi;
        chip_select_n = 1'b1;
        #100;
    endtask : frame
endmodule : hlgc_host

// [bench/test_hex_lowside_gate_control_diag.sv]
// Purpose: Directed frames and pin changes with expected responses.
// Assumes: Shortened blanking and filter counts.
// Notes:   Responses appear during the frame after the request.
`include "hlgc_cfg.svh"
module test_hex_lowside_gate_control_diag
    import hlgc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, resetn, spi_sclk, chip_select_n, spi_mosi, miso;
    logic master_reset_n, global_disable;
    logic [5:0] par_in, drain_over, drain_low, drain_mid, drive_output;
    logic flag_o, flag_oe;
    int err_count, checks;
    hlgc_host host_u (.spi_sclk(spi_sclk), .chip_select_n(chip_select_n),
                      .spi_mosi(spi_mosi), .spi_miso_o(miso));
    hlgc_top #(.ON_CYC('{default: 18'h14}), .OFF_CYC('{default: 18'h28}),
               .FILT_CYC(18'h8), .RETRY_CYC(18'h32)) dut_u (
        .clk(clk), .resetn(resetn), .spi_sclk(spi_sclk), .chip_select_n(chip_select_n),
        .spi_mosi(spi_mosi), .spi_miso_o(miso), .spi_miso_oe(),
        .master_reset_n(master_reset_n), .global_disable(global_disable), .par_in(par_in),
        .drain_feedback_over(drain_over), .drain_feedback_low(drain_low),
        .drain_feedback_mid(drain_mid), .drive_output(drive_output),
        .fault_flag_n_o(flag_o), .fault_flag_n_oe(flag_oe));
    function automatic logic [15:0] wd(input logic [2:0] a, input logic [11:0] d);
        return {a, d, ~^{a, d}};
    endfunction : wd
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_val
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (50000) @(posedge clk);
        err_count++;
        wrap_up();
    end
    initial begin
        logic [15:0] r;
        resetn = 1'b0;
        master_reset_n = 1'b1;
        global_disable = 1'b0;
        par_in = '0;
        drain_over = '0;
        drain_low = '0;
        drain_mid = '0;
        repeat (10) @(negedge clk);
        resetn = 1'b1;
        repeat (10) @(negedge clk);
        host_u.frame(wd(3'h7, 12'h5c3), 16, r);
        host_u.frame(wd(3'h7, 12'h0f0), 16, r);
        check_val(r, wd(3'h7, 12'h5c3));
        for (int k = 0; k < 2; k++) begin
            host_u.frame(wd(3'h7, 12'h111) ^ {15'h0, k == 0}, 16 - k, r);
            host_u.frame(wd(3'h7, 12'h222), 16, r);
            host_u.frame(wd(3'h7, 12'h333), 16, r);
            check_val(r, k == 0 ? 16'heaaa : 16'heaa9);
        end
        @(negedge clk) par_in = 6'h12;
        host_u.frame(wd(3'h0, 12'h005), 16, r);
        repeat (8) @(negedge clk);
        check_val({10'h0, drive_output}, 16'h0017);
        global_disable = 1'b1;
        repeat (8) @(negedge clk);
        check_val({10'h0, drive_output}, 16'h0000);
        global_disable = 1'b0;
        repeat (8) @(negedge clk);
        check_val({10'h0, drive_output}, 16'h0017);
        master_reset_n = 1'b0;
        drain_low = 6'h20;
        repeat (8) @(negedge clk);
        check_val({10'h0, drive_output}, 16'h0000);
        master_reset_n = 1'b1;
        repeat (200) @(negedge clk);
        check_val({10'h0, drive_output}, 16'h0012);
        check_val({15'h0, flag_oe}, 16'h0001);
        host_u.frame(wd(3'h4, 12'h000), 16, r);
        host_u.frame(wd(3'h5, 12'h000), 16, r);
        check_val(r, wd(3'h4, 12'h1ea));
        host_u.frame(wd(3'h4, 12'h000), 16, r);
        check_val(r, wd(3'h5, 12'h0ea));
        host_u.frame(wd(3'h6, 12'h000), 16, r);
        check_val(r, wd(3'h4, 12'h1ff));
        host_u.frame(wd(3'h1, 12'h001), 16, r);
        repeat (100) @(negedge clk);
        host_u.frame(wd(3'h4, 12'h000), 16, r);
        host_u.frame(wd(3'h6, 12'h000), 16, r);
        check_val(r, wd(3'h4, 12'h1f6));
        wrap_up();
    end
endmodule : test_hex_lowside_gate_control_diag
bind hlgc_top hlgc_chk chk_u (.clk(clk), .resetn(resetn), .chip_select_n(chip_select_n),
    .spi_miso_oe(spi_miso_oe), .master_reset_n(master_reset_n),
    .global_disable(global_disable), .drive_output(drive_output),
    .fault_flag_n_oe(fault_flag_n_oe));
